// file: inc/hsc_pkg.sv
// Shared constants and carrier types for the hardened SPI controller.
// Assumes one 50 MHz system clock and an active-low asynchronous reset.
package hsc_pkg;

	// --------------------------------------------------------------
	// Widths and clock figures
	// --------------------------------------------------------------
	localparam int          DATA_W       = 8;
	localparam int          FIFO_DEPTH   = 8;
	localparam int          CS_COUNT     = 4;
	localparam int          FLAG_COUNT   = 4;
	localparam int unsigned SYS_CLK_MHZ  = 50;
	localparam int unsigned SYS_CLK_HZ   = SYS_CLK_MHZ * 1000000;
	// Default serial clock rate when software leaves the divider at zero
	localparam int unsigned SCK_RATE_HZ  = 1000000;
	// System clock over desired rate, rounded to nearest
	localparam int unsigned SCK_DIV_INT  = (SYS_CLK_HZ + SCK_RATE_HZ / 2) / SCK_RATE_HZ;
	localparam logic [7:0]  SCK_DIV_DFLT = SCK_DIV_INT[7:0];

	// --------------------------------------------------------------
	// Flag positions and reset values
	// --------------------------------------------------------------
	localparam int          FLG_TX_READY = 0;
	localparam int          FLG_MODE_FLT = 1;
	localparam int          FLG_RX_READY = 2;
	localparam int          FLG_RX_OVRUN = 3;
	localparam logic [3:0]  FLAGS_RST    = 4'h0;
	localparam logic [3:0]  CS_IDLE      = 4'hf;
	localparam logic [7:0]  BYTE_ZERO    = 8'h00;
	localparam logic [3:0]  LAST_EDGE    = 4'hf;
	localparam logic [2:0]  LAST_BIT     = 3'h7;

	// --------------------------------------------------------------
	// Carrier types
	// --------------------------------------------------------------
	typedef struct packed {
		logic       master_select_bit;
		logic       low_bit_first_select;
		logic       cpol;
		logic       cpha;
		logic       slave_handshake_enable;
		logic       wakeup_enable_bit;
		logic [3:0] chip_select_reg;
		logic [7:0] clk_div;
		logic [3:0] interrupt_enable_reg;
	} hsc_cfg_t;

	typedef struct packed {
		logic tx_empty_status;
		logic mode_fault_status;
		logic rx_full_status;
		logic rx_overrun_status;
	} hsc_status_t;

endpackage

// file: rtl/hsc_fifo.sv
// Flop-based FIFO with valid/ready on both sides.
// Assumes one clock; in_ready and out_valid are registered.
`timescale 1ns/1ps
module hsc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic             flush,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wr_ptr_r;
	logic [PW-1:0]    rd_ptr_r;
	logic [CW-1:0]    count_r;
	logic [CW-1:0]    count_nxt;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign out_data  = mem_r[rd_ptr_r];
	assign count_nxt = flush ? '0 : count_r + CW'(push) - CW'(pop);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_r  <= '0;
			rd_ptr_r  <= '0;
			count_r   <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			count_r   <= count_nxt;
			in_ready  <= count_nxt != FULL_CNT;
			out_valid <= count_nxt != '0;
			if (flush) begin
				wr_ptr_r <= '0;
				rd_ptr_r <= '0;
			end else begin
				if (push)
					wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
				if (pop)
					rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end

endmodule

// file: rtl/hsc_spi_ctrl.sv
// One hardened SPI controller instance, master or slave, with flags.
// Assumes serial pins are synchronous to sys_clk; pads resolve enables.
`timescale 1ns/1ps
module hsc_spi_ctrl (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst_b,
	// Control and configuration
	input  wire logic                core_enable,
	input  wire hsc_pkg::hsc_cfg_t   cfg,
	input  wire logic          [3:0] irq_clear,
	input  wire logic                rx_take,
	// Transmit stream
	input  wire logic                tx_valid,
	input  wire logic          [7:0] tx_data,
	output logic                     tx_ready,
	// Receive data and status
	output logic               [7:0] receive_data_reg,
	output hsc_pkg::hsc_status_t     status,
	output logic               [3:0] interrupt_flag_reg,
	output logic                     wakeup_out,
	// Serial pins
	input  wire logic                sclk_in,
	output logic                     sclk_out,
	output logic                     sclk_oe_b,
	input  wire logic                mosi_in,
	output logic                     mosi_out,
	output logic                     mosi_oe_b,
	input  wire logic                miso_in,
	output logic                     miso_out,
	output logic                     miso_oe_b,
	input  wire logic                slave_chip_select_in,
	output logic               [3:0] master_chip_select_out
);
	typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_END} hsc_mst_state_t;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	hsc_mst_state_t st_r, st_nxt;
	logic       mst_r;
	logic [7:0] div_cnt_r;
	logic [3:0] edge_cnt_r;
	logic [2:0] bit_cnt_r;
	logic       first_r;
	logic       loaded_r;
	logic [7:0] tx_sh_r, tx_sh_nxt;
	logic [7:0] rx_sh_r;
	logic       rx_full_r;
	logic [3:0] flags_r;
	logic [3:0] flags_nxt;
	logic       sclk_q_r;
	logic       cs_q_r;
	logic       sclk_r;

	// ------------------------------------------------------------------
	// Transmit FIFO
	// ------------------------------------------------------------------
	logic       f_valid;
	logic [7:0] f_data;
	wire        f_pop;

	hsc_fifo #(
		.WIDTH (hsc_pkg::DATA_W),
		.DEPTH (hsc_pkg::FIFO_DEPTH)
	) u_tx_fifo (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.flush     (!core_enable),
		.in_valid  (tx_valid),
		.in_data   (tx_data),
		.in_ready  (tx_ready),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (f_pop)
	);

	// ------------------------------------------------------------------
	// Divider and edge decode
	// ------------------------------------------------------------------
	wire [7:0] div_w    = (cfg.clk_div == hsc_pkg::BYTE_ZERO) ? hsc_pkg::SCK_DIV_DFLT
	                                                           : cfg.clk_div;
	wire [7:0] half_w   = (div_w < 8'h02) ? 8'h01 : {1'b0, div_w[7:1]};
	wire       running  = st_r != ST_IDLE;
	wire       tick     = running && (div_cnt_r == half_w - 8'h01);
	wire       fault    = mst_r && !slave_chip_select_in;
	wire       slv_sel  = !mst_r && !slave_chip_select_in;
	wire       cs_fall  = !mst_r && cs_q_r && !slave_chip_select_in;
	// Leading edge leaves the idle level set by the inversion bit
	wire       s_lead   = slv_sel && (sclk_q_r == cfg.cpol) && (sclk_in != cfg.cpol);
	wire       s_trail  = slv_sel && (sclk_q_r != cfg.cpol) && (sclk_in == cfg.cpol);
	wire       m_edge   = tick && st_r == ST_XFER;
	wire       m_lead   = m_edge && !edge_cnt_r[0];
	wire       m_trail  = m_edge && edge_cnt_r[0];
	// Handshake holds the slave off edges until data is loaded
	wire       hs_hold  = !mst_r && cfg.slave_handshake_enable && !loaded_r;
	wire       lead     = mst_r ? m_lead : (s_lead && !hs_hold);
	wire       trail    = mst_r ? m_trail : (s_trail && !hs_hold);
	wire       samp_ev  = cfg.cpha ? trail : lead;
	wire       launch   = cfg.cpha ? lead : trail;
	wire       din      = mst_r ? miso_in : mosi_in;
	wire       byte_done = samp_ev && bit_cnt_r == hsc_pkg::LAST_BIT;
	wire [7:0] rx_next  = cfg.low_bit_first_select ? {din, rx_sh_r[7:1]}
	                                               : {rx_sh_r[6:0], din};
	wire       dout     = cfg.low_bit_first_select ? tx_sh_r[0] : tx_sh_r[7];

	// ------------------------------------------------------------------
	// Byte loading
	// ------------------------------------------------------------------
	wire m_load = mst_r && f_valid && !fault &&
	              ((st_r == ST_IDLE) || (st_r == ST_END && tick));
	// Handshake reloads only while selected
	wire s_load_pt = !mst_r && (cs_fall || (byte_done && slv_sel) || (hs_hold && slv_sel));
	wire load     = m_load || s_load_pt;
	assign f_pop  = load && f_valid;

	always_comb begin
		tx_sh_nxt = tx_sh_r;
		if (load)
			tx_sh_nxt = f_valid ? f_data : hsc_pkg::BYTE_ZERO;
		else if (launch && !first_r)
			tx_sh_nxt = cfg.low_bit_first_select ? {1'b0, tx_sh_r[7:1]}
			                                     : {tx_sh_r[6:0], 1'b0};
	end

	// ------------------------------------------------------------------
	// Master sequencer
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_IDLE: if (m_load) st_nxt = ST_XFER;
			ST_XFER: if (tick && edge_cnt_r == hsc_pkg::LAST_EDGE) st_nxt = ST_END;
			ST_END:  if (tick) st_nxt = f_valid ? ST_XFER : ST_IDLE;
		endcase
		if (fault || !mst_r)
			st_nxt = ST_IDLE;
	end

	// ------------------------------------------------------------------
	// Flags: set wins over write-one clear
	// ------------------------------------------------------------------
	always_comb begin
		flags_nxt = flags_r & ~irq_clear;
		if (!f_valid)
			flags_nxt[hsc_pkg::FLG_TX_READY] = 1'b1;
		if (fault)
			flags_nxt[hsc_pkg::FLG_MODE_FLT] = 1'b1;
		if (byte_done)
			flags_nxt[hsc_pkg::FLG_RX_READY] = 1'b1;
		if (byte_done && rx_full_r)
			flags_nxt[hsc_pkg::FLG_RX_OVRUN] = 1'b1;
	end

	// Disabled instance shows no flags except status.tx_empty_status, taken from the flushed FIFO
	wire [3:0] flags_vis   = core_enable ? flags_nxt : hsc_pkg::FLAGS_RST;
	wire       rx_full_nxt = byte_done || (rx_full_r && !rx_take);
	wire       rx_full_vis = core_enable && rx_full_nxt;

	// ------------------------------------------------------------------
	// Registers; a low enable holds the instance idle
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r       <= ST_IDLE;
			mst_r      <= 1'b0;
			div_cnt_r  <= 8'h00;
			edge_cnt_r <= 4'h0;
			bit_cnt_r  <= 3'h0;
			first_r    <= 1'b0;
			loaded_r   <= 1'b0;
			tx_sh_r    <= hsc_pkg::BYTE_ZERO;
			rx_sh_r    <= hsc_pkg::BYTE_ZERO;
			rx_full_r  <= 1'b0;
			flags_r    <= hsc_pkg::FLAGS_RST;
			sclk_q_r   <= 1'b0;
			cs_q_r     <= 1'b1;
		end else if (!core_enable) begin
			st_r      <= ST_IDLE;
			mst_r     <= 1'b0;
			loaded_r  <= 1'b0;
			rx_full_r <= 1'b0;
			flags_r   <= hsc_pkg::FLAGS_RST;
			cs_q_r    <= 1'b1;
		end else begin
			st_r       <= st_nxt;
			mst_r      <= cfg.master_select_bit;
			div_cnt_r  <= (tick || !running) ? 8'h00 : div_cnt_r + 8'h01;
			edge_cnt_r <= m_load ? 4'h0 : (m_edge ? edge_cnt_r + 4'h1 : edge_cnt_r);
			bit_cnt_r  <= (cs_fall || m_load) ? 3'h0 : (samp_ev ? bit_cnt_r + 3'h1 : bit_cnt_r);
			first_r    <= load ? 1'b1 : ((lead || trail) ? 1'b0 : first_r);
			loaded_r   <= load ? f_valid : (slave_chip_select_in ? 1'b0 : loaded_r);
			tx_sh_r    <= tx_sh_nxt;
			rx_sh_r    <= samp_ev ? rx_next : rx_sh_r;
			rx_full_r  <= rx_full_nxt;
			flags_r    <= flags_nxt;
			sclk_q_r   <= sclk_in;
			cs_q_r     <= slave_chip_select_in;
		end
	end

	// ------------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_r                 <= 1'b0;
			receive_data_reg       <= hsc_pkg::BYTE_ZERO;
			status                 <= '0;
			interrupt_flag_reg     <= hsc_pkg::FLAGS_RST;
			wakeup_out             <= 1'b0;
			sclk_oe_b              <= 1'b1;
			mosi_out               <= 1'b0;
			mosi_oe_b              <= 1'b1;
			miso_out               <= 1'b0;
			miso_oe_b              <= 1'b1;
			master_chip_select_out <= hsc_pkg::CS_IDLE;
		end else begin
			sclk_r             <= running ? (m_edge ? !sclk_r : sclk_r) : cfg.cpol;
			receive_data_reg   <= byte_done ? rx_next : receive_data_reg;
			status             <= {!f_valid, flags_vis[hsc_pkg::FLG_MODE_FLT],
			                       rx_full_vis, flags_vis[hsc_pkg::FLG_RX_OVRUN]};
			interrupt_flag_reg <= flags_vis & cfg.interrupt_enable_reg;
			wakeup_out         <= cfg.wakeup_enable_bit && cs_fall && core_enable;
			sclk_oe_b          <= !(mst_r && core_enable);
			mosi_out           <= dout;
			mosi_oe_b          <= !(mst_r && running);
			miso_out           <= hs_hold ? 1'b1 : dout;
			miso_oe_b          <= !(slv_sel && core_enable);
			master_chip_select_out <= (running && st_nxt != ST_IDLE)
			                          ? ~cfg.chip_select_reg : hsc_pkg::CS_IDLE;
		end
	end
	assign sclk_out = sclk_r;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	property p_disable_idle;
		!core_enable |=> st_r == ST_IDLE && flags_r == hsc_pkg::FLAGS_RST;
	endproperty
	a_disable_idle: assert property (p_disable_idle) else $error("disabled instance not idle");

	property p_slave_default;
		$past(!mst_r) |-> sclk_oe_b && master_chip_select_out == hsc_pkg::CS_IDLE;
	endproperty
	a_slave_default: assert property (p_slave_default) else $error("slave drives master pins");

	property p_sck_toggle;
		m_edge |=> sclk_out != $past(sclk_out);
	endproperty
	a_sck_toggle: assert property (p_sck_toggle) else $error("serial clock missed a tick");

	property p_cs_mask;
		##1 ((~master_chip_select_out) & ~$past(cfg.chip_select_reg)) == 4'h0;
	endproperty
	a_cs_mask: assert property (p_cs_mask) else $error("masked chip select asserted");

	property p_tx_flag;
		(!f_valid && core_enable) |=> flags_r[hsc_pkg::FLG_TX_READY];
	endproperty
	a_tx_flag: assert property (p_tx_flag) else $error("transmit-ready flag not set");

	property p_mode_fault;
		(fault && core_enable) |=> flags_r[hsc_pkg::FLG_MODE_FLT] && st_r == ST_IDLE;
	endproperty
	a_mode_fault: assert property (p_mode_fault) else $error("mode fault not flagged");

	property p_rx_ready;
		(byte_done && core_enable) |=> status.rx_full_status ##0
		    receive_data_reg == $past(rx_next);
	endproperty
	a_rx_ready: assert property (p_rx_ready) else $error("received byte not presented");

	property p_overrun;
		(byte_done && rx_full_r && core_enable) |=> flags_r[hsc_pkg::FLG_RX_OVRUN];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	property p_irq_gate;
		##1 (interrupt_flag_reg & ~$past(cfg.interrupt_enable_reg)) == 4'h0;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("disabled flag signalled");

	property p_wakeup;
		wakeup_out |-> $past(cfg.wakeup_enable_bit) && !$past(mst_r);
	endproperty
	a_wakeup: assert property (p_wakeup) else $error("wakeup without enable");

	property p_handshake;
		hs_hold && core_enable |=> miso_out;
	endproperty
	a_handshake: assert property (p_handshake) else $error("handshake idle level wrong");

endmodule

// file: verification/hsc_spi_ctrl_tb.sv
// Self-checking bench for one SPI controller facing a slave device model.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
module hsc_spi_ctrl_tb;
	// --------------------------------------------------------------
	// Signals
	// --------------------------------------------------------------
	logic                 sys_clk;
	logic                 rst_b;
	logic                 core_enable;
	hsc_pkg::hsc_cfg_t    cfg;
	logic           [3:0] irq_clear;
	logic                 rx_take;
	logic                 tx_valid;
	logic           [7:0] tx_data;
	logic                 tx_ready;
	logic           [7:0] receive_data_reg;
	hsc_pkg::hsc_status_t status;
	logic           [3:0] interrupt_flag_reg;
	logic                 wakeup_out;
	logic                 sclk_in;
	logic                 sclk_out;
	logic                 sclk_oe_b;
	logic                 mosi_in;
	logic                 mosi_out;
	logic                 mosi_oe_b;
	logic                 miso;
	logic                 miso_out;
	logic                 miso_oe_b;
	logic                 scs_b;
	logic           [3:0] master_chip_select_out;
	logic           [7:0] resp_byte;
	logic           [7:0] got_byte;
	logic           [7:0] exp_q[$];
	logic                 rx_full_r;
	logic                 s;
	int                   n_mismatch;
	int                   check_count;
	int                   seed;
	int                   n;

	hsc_spi_ctrl hsc_spi_ctrl_inst (
		.sys_clk(sys_clk), .rst_b(rst_b), .core_enable(core_enable), .cfg(cfg),
		.irq_clear(irq_clear), .rx_take(rx_take), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .receive_data_reg(receive_data_reg), .status(status),
		.interrupt_flag_reg(interrupt_flag_reg), .wakeup_out(wakeup_out),
		.sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe_b(sclk_oe_b), .mosi_in(mosi_in),
		.mosi_out(mosi_out), .mosi_oe_b(mosi_oe_b), .miso_in(miso), .miso_out(miso_out),
		.miso_oe_b(miso_oe_b), .slave_chip_select_in(scs_b),
		.master_chip_select_out(master_chip_select_out));

	hsc_spi_slave_model hsc_spi_slave_model_inst (
		.sclk(sclk_out), .cs_b(master_chip_select_out[0]), .mosi(mosi_out), .miso(miso),
		.cpol(cfg.cpol), .cpha(cfg.cpha), .lsb_first(cfg.low_bit_first_select),
		.resp_byte(resp_byte), .got_byte(got_byte));

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		if (n_mismatch == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic push(input logic [7:0] b);
		tx_valid <= 1'b1;
		tx_data <= b;
		@(posedge sys_clk);
		for (n = 0; n < 500 && tx_ready !== 1'b1; n++) @(posedge sys_clk);
		chk({7'h0, tx_ready}, 8'h01);
		tx_valid <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic clr(input logic [3:0] m);
		irq_clear <= m;
		@(posedge sys_clk);
		irq_clear <= 4'h0;
		repeat (2) @(posedge sys_clk);
	endtask

	task automatic take;
		for (n = 0; n < 2000 && status.rx_full_status !== 1'b1; n++) @(posedge sys_clk);
		chk({7'h0, status.rx_full_status}, 8'h01);
		rx_take <= 1'b1;
		@(posedge sys_clk);
		rx_take <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic xfer(input logic [7:0] b, input int half);
		chk({7'h0, sclk_out}, {7'h0, cfg.cpol});
		exp_q.push_back(resp_byte);
		push(b);
		for (n = 0; n < 200 && master_chip_select_out[0] !== 1'b0; n++) @(posedge sys_clk);
		chk({4'h0, master_chip_select_out}, {4'h0, ~cfg.chip_select_reg});
		chk({7'h0, mosi_oe_b}, 8'h00);
		s = sclk_out;
		for (n = 0; n < 400 && sclk_out === s; n++) @(posedge sys_clk);
		s = sclk_out;
		for (n = 0; n < 400 && sclk_out === s; n++) @(posedge sys_clk);
		chk(n[7:0], half[7:0]);
		take();
		chk(got_byte, b);
		chk({7'h0, interrupt_flag_reg[2]}, {7'h0, cfg.interrupt_enable_reg[2]});
		for (n = 0; n < 200 && master_chip_select_out[0] !== 1'b1; n++) @(posedge sys_clk);
	endtask

	// Oldest expected byte against each newly received byte
	always @(posedge sys_clk) begin
		rx_full_r <= status.rx_full_status;
		if (status.rx_full_status === 1'b1 && rx_full_r === 1'b0 && exp_q.size() > 0) begin
			chk(receive_data_reg, exp_q.pop_front());
		end
	end

	// --------------------------------------------------------------
	// Clock, watchdog and main sequence
	// --------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		stop_test();
	end

	initial begin
		seed = 15461;
		n_mismatch = 0;
		check_count = 0;
		rst_b = 1'b0;
		core_enable = 1'b1;
		cfg = '0;
		irq_clear = 4'h0;
		rx_take = 1'b0;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		sclk_in = 1'b0;
		mosi_in = 1'b0;
		scs_b = 1'b1;
		resp_byte = 8'h00;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk({7'h0, sclk_oe_b}, 8'h01);
		chk({4'h0, master_chip_select_out}, 8'h0f);
		chk({4'h0, interrupt_flag_reg}, 8'h00);
		chk({7'h0, status.tx_empty_status}, 8'h01);
		cfg.interrupt_enable_reg <= 4'hf;
		repeat (3) @(posedge sys_clk);
		chk({7'h0, interrupt_flag_reg[0]}, 8'h01);
		clr(4'h1);
		chk({7'h0, interrupt_flag_reg[0]}, 8'h01);
		for (int m = 0; m < 8; m++) begin
			cfg.master_select_bit <= 1'b1;
			cfg.cpol <= m[0];
			cfg.cpha <= m[1];
			cfg.low_bit_first_select <= m[2];
			cfg.clk_div <= m[0] ? 8'h06 : 8'h04;
			cfg.chip_select_reg <= m[1] ? 4'h5 : 4'h1;
			cfg.interrupt_enable_reg <= m[2] ? 4'hb : 4'hf;
			resp_byte <= 8'($random(seed));
			repeat (4) @(posedge sys_clk);
			xfer(8'($random(seed)), m[0] ? 3 : 2);
			clr(4'h4);
			chk({7'h0, interrupt_flag_reg[2]}, 8'h00);
		end
		cfg.interrupt_enable_reg <= 4'hf;
		exp_q.push_back(resp_byte);
		push(8'h3c);
		push(8'hc3);
		for (n = 0; n < 2000 && status.rx_overrun_status !== 1'b1; n++) @(posedge sys_clk);
		repeat (2) @(posedge sys_clk);
		chk({7'h0, interrupt_flag_reg[3]}, 8'h01);
		cfg.interrupt_enable_reg <= 4'h7;
		repeat (2) @(posedge sys_clk);
		chk({7'h0, interrupt_flag_reg[3]}, 8'h00);
		take();
		cfg.interrupt_enable_reg <= 4'hf;
		clr(4'hc);
		chk({7'h0, interrupt_flag_reg[3]}, 8'h00);
		scs_b <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk({7'h0, interrupt_flag_reg[1]}, 8'h01);
		chk({7'h0, status.mode_fault_status}, 8'h01);
		cfg.master_select_bit <= 1'b0;
		scs_b <= 1'b1;
		clr(4'h2);
		chk({7'h0, interrupt_flag_reg[1]}, 8'h00);
		for (int w = 1; w >= 0; w--) begin
			cfg.wakeup_enable_bit <= w[0];
			cfg.slave_handshake_enable <= 1'b1;
			repeat (2) @(posedge sys_clk);
			scs_b <= 1'b0;
			n = 0;
			repeat (6) begin
				@(posedge sys_clk);
				if (wakeup_out === 1'b1) n++;
			end
			chk(n[7:0], w[7:0]);
			chk({7'h0, miso_out}, 8'h01);
			chk({7'h0, miso_oe_b}, 8'h00);
			scs_b <= 1'b1;
			repeat (2) @(posedge sys_clk);
		end
		cfg.slave_handshake_enable <= 1'b0;
		tx_valid <= 1'b1;
		tx_data <= 8'($random(seed));
		n = 0;
		repeat (12) begin
			@(posedge sys_clk);
			if (tx_ready === 1'b1) begin
				n++;
				tx_data <= 8'($random(seed));
			end
		end
		tx_valid <= 1'b0;
		chk(n[7:0], 8'h08);
		repeat (8) exp_q.push_back(resp_byte);
		cfg.master_select_bit <= 1'b1;
		repeat (8) take();
		chk(8'(exp_q.size()), 8'h00);
		core_enable <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk({4'h0, interrupt_flag_reg}, 8'h00);
		stop_test();
	end
endmodule

// file: verification/hsc_spi_slave_model.sv
// Behavioural SPI slave device that answers the controller in master mode.
// Assumes cs_b active low and resp_byte stable while selected.
`timescale 1ns/1ps
module hsc_spi_slave_model (
	// Serial pins
	input  wire logic       sclk,
	input  wire logic       cs_b,
	input  wire logic       mosi,
	output logic            miso,
	// Mode and data
	input  wire logic       cpol,
	input  wire logic       cpha,
	input  wire logic       lsb_first,
	input  wire logic [7:0] resp_byte,
	output logic      [7:0] got_byte
);
	logic [7:0] rx_sr;
	int         k;
	int         ns;

	function automatic logic pick(input int i);
		return lsb_first ? resp_byte[i] : resp_byte[7-i];
	endfunction

	initial begin
		miso = 1'b0;
		got_byte = 8'h00;
		rx_sr = 8'h00;
		k = 0;
		ns = 0;
	end

	// First bit ready before the first edge when phase is zero
	always @(negedge cs_b) begin
		k = 0;
		ns = 0;
		if (!cpha) begin
			miso = pick(0);
			k = 1;
		end
	end

	// Released line shows the inverse, never a held value
	always @(posedge cs_b) miso = ~miso;

	// Sample on one edge, launch on the other
	always @(sclk) begin
		if (!cs_b && ((sclk != cpol) == !cpha)) begin
			rx_sr = lsb_first ? {mosi, rx_sr[7:1]} : {rx_sr[6:0], mosi};
			got_byte = rx_sr;
			ns++;
			// Next byte of a burst starts its bit count afresh
			if (ns == 8) begin
				ns = 0;
				k = 0;
			end
		end else if (!cs_b && k < 8) begin
			miso = pick(k);
			k++;
		end
	end
endmodule
